// ==== design/vtp_cfg.svh ====
// Operation
// - select zero puts vectors at flash base
// - select one moves vectors to boot base
// - 2K boot relocated first vector at 1c02
// - boot reset unprogrammed starts at zero
// - boot reset programmed starts at boot base
// - select changes only within four-cycle window
// - block interrupts from enable until after next
// - no select write, block four cycles
// - global interrupt flag left untouched
// - enable clears after four cycles or write
// - select write needs prior change enable
// - boot vectors plus lock block application interrupts
// - app vectors plus lock block boot interrupts
// - enable bit0, select bit1, reset zero
// - boot reset setting zero means programmed
// - two-word slots, last vector 21 at 02a
`ifndef VTP_CFG_SVH
`define VTP_CFG_SVH
`define GIC_ADDR         2'h0
`define STATUS_ADDR      2'h1
`define CE_BIT           0
`define SEL_BIT          1
`define EXT_MSB          7
`define EXT_LSB          5
`define GIC_RESET        8'h00
`define WIN_CYCLES       3'h4
`define WIN_LAST         3'h1
`define FIRST_VEC_OFS    13'h0002
`define LAST_VEC_NUM     5'h15
`define APP_BASE         13'h0000
`define BOOT_BASE_256W   13'h1f00
`define BOOT_BASE_512W   13'h1e00
`define BOOT_BASE_1KW    13'h1c00
`define BOOT_BASE_2KW    13'h1800
`define FUSE_PROGRAMMED  1'h0
`endif

// ==== design/vtp_pkg.sv ====
package vtp_pkg;
    typedef logic [12:0] waddr_t;
    typedef struct packed {
        logic       boot_reset_setting;   // 0 = programmed
        logic [1:0] boot_size_setting;
        logic       app_side_boot_lock;   // 0 = programmed
        logic       boot_side_boot_lock;  // 0 = programmed
    } fuse_s;
    typedef struct packed {
        logic [7:0] dat;
        logic       ack;
    } wb_rsp_s;
    typedef enum logic [1:0] {idle, window_open, hold_one} lock_e;
endpackage

// ==== design/vector_addr_calc.sv ====
`timescale 1ns/1ps
`include "vtp_cfg.svh"
module vector_addr_calc (
    input  wire vtp_pkg::fuse_s  fuse_i,      // configuration settings
    input  wire logic            sel_i,       // vector select
    input  wire logic [4:0]      vec_num_i,   // vector number 1..21
    input  wire logic [12:0]     pc_i,        // executing word address
    output      vtp_pkg::waddr_t boot_base_o, // boot area base
    output      vtp_pkg::waddr_t reset_addr_o,// reset entry
    output      vtp_pkg::waddr_t vec_addr_o,  // fetch address
    output      logic            pc_in_boot_o // executing in boot area
);
    import vtp_pkg::*;
    // --------------------------------
    // boot base from size setting
    // --------------------------------
    function automatic waddr_t base_of(input logic [1:0] sz);
        unique case (sz)
            2'h0: base_of = `BOOT_BASE_2KW;
            2'h1: base_of = `BOOT_BASE_1KW; // 2K byte area
            2'h2: base_of = `BOOT_BASE_512W;
            2'h3: base_of = `BOOT_BASE_256W;
        endcase
    endfunction
    waddr_t tbl;
    // table base and offsets, two words per slot
    always_comb begin
        boot_base_o  = base_of(fuse_i.boot_size_setting);
        tbl          = sel_i ? boot_base_o : `APP_BASE;
        vec_addr_o   = tbl + {7'h00, vec_num_i, 1'b0};
        reset_addr_o = (fuse_i.boot_reset_setting == `FUSE_PROGRAMMED)
                       ? boot_base_o : `APP_BASE;
        pc_in_boot_o = (pc_i >= boot_base_o);
    end
endmodule

// ==== design/vector_table_placement.sv ====
`timescale 1ns/1ps
`include "vtp_cfg.svh"
module vector_table_placement (
    input  wire logic            clk_i,       // 50 MHz clock
    input  wire logic            rst_i,       // sync reset, high
    input  wire logic            cyc_i,       // wishbone cycle
    input  wire logic            stb_i,       // wishbone strobe
    input  wire logic            we_i,        // write enable
    input  wire logic [1:0]      adr_i,       // word address
    input  wire logic [3:0]      sel_i,       // byte enables
    input  wire logic [31:0]     dat_i,       // write data
    output      logic [31:0]     dat_o,       // read data
    output      logic            ack_o,       // acknowledge
    input  wire vtp_pkg::fuse_s  fuse_i,      // configuration settings
    input  wire logic [12:0]     pc_i,        // executing word address
    input  wire logic            instr_done_i,// instruction retired pulse
    input  wire logic [4:0]      vec_num_i,   // requested vector number
    output      vtp_pkg::waddr_t vec_addr_o,  // vector fetch address
    output      vtp_pkg::waddr_t reset_addr_o,// reset entry address
    output      logic            vector_select_o, // current select
    output      logic            irq_block_o  // interrupt acceptance blocked
);
    import vtp_pkg::*;
    // reset image of the control register, bits picked out by position
    localparam logic [7:0] GIC_INIT = `GIC_RESET;
    // ------------------------------------------------
    // register state
    // ------------------------------------------------
    logic       sel_q, sel_d;
    logic       ce_q, ce_d;
    logic [2:0] ext_q, ext_d;
    logic [2:0] cnt_q, cnt_d;
    lock_e      st_q, st_d;
    logic       ack_q, ack_d;
    logic [7:0] rd_q, rd_d;
    logic       wr, rd, wr_b0;
    waddr_t     boot_base;
    logic       in_boot;
    // bus decode; only byte lane 0 holds data
    assign wr    = cyc_i & stb_i & we_i & ~ack_q;
    assign rd    = cyc_i & stb_i & ~we_i & ~ack_q;
    assign wr_b0 = wr & sel_i[0] & (adr_i == `GIC_ADDR);
    // ------------------------------------------------
    // address calculation
    // ------------------------------------------------
    vector_addr_calc u_calc (
        .fuse_i       (fuse_i),
        .sel_i        (sel_q),
        .vec_num_i    (vec_num_i),
        .pc_i         (pc_i),
        .boot_base_o  (boot_base),
        .reset_addr_o (reset_addr_o),
        .vec_addr_o   (vec_addr_o),
        .pc_in_boot_o (in_boot)
    );
    // ------------------------------------------------
    // control register next state
    // ------------------------------------------------
    always_comb begin
        sel_d = sel_q;
        ce_d  = ce_q;
        ext_d = ext_q;
        cnt_d = cnt_q;
        st_d  = st_q;
        // window counter runs down while enable is set
        if (ce_q) begin
            cnt_d = cnt_q - 3'h1;
            if (cnt_q == `WIN_LAST) begin
                ce_d = 1'b0;
                st_d = idle;
            end
        end
        // a hold ends after the instruction following the write
        if (st_q == hold_one && instr_done_i) begin
            st_d = idle;
        end
        if (wr_b0) begin
            ext_d = dat_i[`EXT_MSB:`EXT_LSB];
            if (dat_i[`CE_BIT]) begin
                // writing one opens or restarts the window
                ce_d  = 1'b1;
                cnt_d = `WIN_CYCLES;
                st_d  = window_open;
            end else if (ce_q) begin
                // select only changes inside the window
                sel_d = dat_i[`SEL_BIT];
                ce_d  = 1'b0;
                st_d  = hold_one;
            end
            // outside the window select stays as it was
        end
    end
    // control registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sel_q <= GIC_INIT[`SEL_BIT];
            ce_q  <= GIC_INIT[`CE_BIT];
            ext_q <= GIC_INIT[`EXT_MSB:`EXT_LSB];
            cnt_q <= 3'h0;
            st_q  <= idle;
        end else begin
            sel_q <= sel_d;
            ce_q  <= ce_d;
            ext_q <= ext_d;
            cnt_q <= cnt_d;
            st_q  <= st_d;
        end
    end
    // ------------------------------------------------
    // interrupt blocking
    // ------------------------------------------------
    // global enable flag lives in the core, never touched here
    always_comb begin
        irq_block_o = (st_q != idle) | (wr_b0 & dat_i[`CE_BIT]);
        if (sel_q && fuse_i.app_side_boot_lock == `FUSE_PROGRAMMED && !in_boot) begin
            irq_block_o = 1'b1;
        end
        if (!sel_q && fuse_i.boot_side_boot_lock == `FUSE_PROGRAMMED && in_boot) begin
            irq_block_o = 1'b1;
        end
    end
    assign vector_select_o = sel_q;
    // ------------------------------------------------
    // wishbone answer, one registered ack per request, one wait state
    // ------------------------------------------------
    always_comb begin
        ack_d = (cyc_i & stb_i) & ~ack_q;
        rd_d  = rd_q;
        if (rd) begin
            unique case (adr_i)
                `GIC_ADDR:    rd_d = {ext_q, 3'h0, sel_q, ce_q};
                `STATUS_ADDR: rd_d = {5'h00, cnt_q};
                default:      rd_d = 8'h00;
            endcase
        end
    end
    // response registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rd_q  <= 8'h00;
        end else begin
            ack_q <= ack_d;
            rd_q  <= rd_d;
        end
    end
    assign ack_o = ack_q;
    assign dat_o = {24'h000000, rd_q};
endmodule

// ==== bench/vtp_props.sv ====
`timescale 1ns/1ps
module vtp_props (
    input wire logic            clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, vector_select_o, irq_block_o,
    input wire logic [1:0]      adr_i,
    input wire logic [3:0]      sel_i,
    input wire logic [31:0]     dat_i,
    input wire logic [4:0]      vec_num_i,
    input wire logic [12:0]     pc_i,
    input wire vtp_pkg::fuse_s  fuse_i,
    input wire vtp_pkg::waddr_t vec_addr_o, reset_addr_o
);
    import vtp_pkg::*;
    logic        wr, ce, selw, quiet, sz1;
    logic [12:0] ofs;
    // taken writes only; quiet means no lock setting blocks by itself
    assign wr    = cyc_i && stb_i && we_i && !ack_o;
    assign ce    = wr && adr_i == 2'h0 && sel_i[0] && dat_i[1:0] == 2'h1;
    assign selw  = wr && adr_i == 2'h0 && sel_i[0] && !dat_i[0];
    assign quiet = fuse_i.app_side_boot_lock && fuse_i.boot_side_boot_lock;
    assign sz1   = fuse_i.boot_size_setting == 2'h1;
    assign ofs   = {7'h00, vec_num_i, 1'b0};
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_app; !vector_select_o |-> vec_addr_o == ofs; endproperty
    a_app: assert property (p_app) else $error("app vector address wrong");
    property p_boot; vector_select_o && sz1 |-> vec_addr_o == 13'h1c00 + ofs; endproperty
    a_boot: assert property (p_boot) else $error("boot vector address wrong");
    property p_rst0; fuse_i.boot_reset_setting |-> reset_addr_o == 13'h0000; endproperty
    a_rst0: assert property (p_rst0) else $error("reset entry not zero");
    property p_rst1; !fuse_i.boot_reset_setting && sz1 |-> reset_addr_o == 13'h1c00; endproperty
    a_rst1: assert property (p_rst1) else $error("reset entry not boot base");
    property p_blk; ce |=> irq_block_o [*3]; endproperty
    a_blk: assert property (p_blk) else $error("block missing in window");
    property p_four; (ce && quiet) ##1 !wr [*4] |=> !irq_block_o; endproperty
    a_four: assert property (p_four) else $error("block outlived window");
    property p_sel; $changed(vector_select_o) |-> $past(selw); endproperty
    a_sel: assert property (p_sel) else $error("select moved without write");
    property p_lock; vector_select_o && !fuse_i.app_side_boot_lock && sz1 && pc_i < 13'h1c00 |-> irq_block_o; endproperty
    a_lock: assert property (p_lock) else $error("lock did not block");
    property p_lockb; !vector_select_o && !fuse_i.boot_side_boot_lock && sz1 && pc_i >= 13'h1c00 |-> irq_block_o; endproperty
    a_lockb: assert property (p_lockb) else $error("boot side lock did not block");
    // main scenarios: full move sequence, both directions
    c_move: cover property (ce ##3 selw);
    c_rise: cover property ($rose(vector_select_o));
    c_fall: cover property ($fell(vector_select_o));
endmodule

// ==== bench/core_model.sv ====
`timescale 1ns/1ps
module core_model (
    input  wire logic        clk_i,     // core clock
    input  wire logic        rst_i,     // sync reset
    input  wire logic        run_i,     // retire instructions
    input  wire logic [12:0] pc_base_i, // code region
    output      logic [12:0] pc_o,      // executing address
    output      logic        done_o     // retire pulse
);
    logic [3:0] cnt_q;
    // core loops in a small region; retiring one in four keeps the hold visible
    always_ff @(posedge clk_i) begin
        cnt_q  <= rst_i ? 4'h0 : cnt_q + 4'h1;
        pc_o   <= pc_base_i + {9'h000, cnt_q};
        done_o <= run_i && cnt_q[1:0] == 2'h3;
    end
endmodule

// ==== bench/vector_table_placement_bench.sv ====
`timescale 1ns/1ps
module vector_table_placement_bench;
    import vtp_pkg::*;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, run = 1'b0;
    logic [1:0]  adr_i = 2'h0;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    logic        ack_o, instr_done_i, vector_select_o, irq_block_o;
    logic [4:0]  vec_num_i = 5'h01;
    logic [12:0] pc_i, pc_base = 13'h0100;
    fuse_s       fuse_i = 5'h1f;
    waddr_t      vec_addr_o, reset_addr_o;
    int          mismatches = 0, cmp_count = 0;
    always #10 clk_i = ~clk_i;
    vector_table_placement u_vector_table_placement (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
        .dat_o, .ack_o, .fuse_i, .pc_i, .instr_done_i, .vec_num_i, .vec_addr_o, .reset_addr_o, .vector_select_o,
        .irq_block_o);
    core_model u_core_model (.clk_i, .rst_i, .run_i(run), .pc_base_i(pc_base), .pc_o(pc_i), .done_o(instr_done_i));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            mismatches++;
            $display("CHECK FAILED %0t seen %h want %h", $time, s, e);
        end
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // one classic cycle; request stands until ack is sampled, then cyc drops a cycle
    task automatic wb(input logic w, input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'h3, w, a, 4'hf, 24'h000000, d};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rd = dat_o;
        {cyc_i, stb_i} <= 2'h0;
    endtask
    function automatic waddr_t base(input logic [1:0] z);
        return (z == 2'h0) ? 13'h1800 : (z == 2'h1) ? 13'h1c00 : (z == 2'h2) ? 13'h1e00 : 13'h1f00;
    endfunction
    // every boot size and reset setting, table ends plus random vectors
    task automatic addr_sweep;
        for (int i = 0; i < 16; i++) begin
            @(posedge clk_i);
            vec_num_i <= (i < 4) ? (i[0] ? 5'h15 : 5'h01) : 5'($urandom_range(21, 1));
            fuse_i <= {i[0], i[2:1], 2'h3};
            #1;
            chk(vec_addr_o, (vector_select_o ? base(fuse_i.boot_size_setting) : 13'h0000) + {vec_num_i, 1'b0});
            chk(reset_addr_o, fuse_i.boot_reset_setting ? 13'h0000 : base(fuse_i.boot_size_setting));
        end
    endtask
    // both locks programmed: only the side holding the vectors may take interrupts
    task automatic lock_chk;
        for (int i = 0; i < 2; i++) begin
            @(posedge clk_i);
            fuse_i <= 5'h14;
            pc_base <= i[0] ? 13'h1c10 : 13'h0100;
            repeat (3) @(posedge clk_i);
            chk(irq_block_o, vector_select_o ^ i[0]);
        end
        fuse_i <= 5'h1f;
    endtask
    initial begin
        void'($urandom(88972));
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 2'h0, 8'h00);
        chk(rd, 32'h0);
        wb(1'b1, 2'h3, 8'($urandom));
        wb(1'b0, 2'h3, 8'h00);
        chk(rd, 32'h0);
        wb(1'b1, 2'h0, 8'he2);
        chk(vector_select_o, 1'b0);
        wb(1'b0, 2'h0, 8'h00);
        chk(rd, 32'he0);
        $display("test reset and refusals done");
        wb(1'b1, 2'h0, 8'h01);
        chk(irq_block_o, 1'b1);
        wb(1'b1, 2'h0, 8'h02);
        chk(vector_select_o, 1'b1);
        chk(irq_block_o, 1'b1);
        wb(1'b0, 2'h0, 8'h00);
        chk(rd, 32'h2);
        run <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk(irq_block_o, 1'b0);
        $display("test move to boot done");
        addr_sweep;
        lock_chk;
        $display("test addresses and locks done");
        wb(1'b1, 2'h0, 8'h01);
        // status read is taken two edges into the four-cycle window
        wb(1'b0, 2'h1, 8'h00);
        chk(rd, 32'h2);
        repeat (4) @(posedge clk_i);
        chk(irq_block_o, 1'b0);
        wb(1'b1, 2'h0, 8'h00);
        chk(vector_select_o, 1'b1);
        $display("test lapsed window done");
        // reset in mid-run with the window open drops select and blocking
        wb(1'b1, 2'h0, 8'h01);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        chk(vector_select_o, 1'b0);
        chk(irq_block_o, 1'b0);
        wb(1'b0, 2'h0, 8'h00);
        chk(rd, 32'h0);
        wb(1'b1, 2'h0, 8'h01);
        wb(1'b1, 2'h0, 8'h02);
        chk(vector_select_o, 1'b1);
        $display("test mid-run reset done");
        wb(1'b1, 2'h0, 8'h01);
        wb(1'b1, 2'h0, 8'h00);
        chk(vector_select_o, 1'b0);
        lock_chk;
        $display("test move back done");
        final_report;
    end
    // watchdog far beyond the hundred or so cycles the tests need
    initial begin
        #400000;
        mismatches++;
        final_report;
    end
endmodule
bind vector_table_placement vtp_props u_vtp_props (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .ack_o, .fuse_i, .pc_i, .vec_num_i, .vec_addr_o, .reset_addr_o, .vector_select_o, .irq_block_o);
